// >>> verilog/smsh_status.sv
/*
  Status register and command/response handshake of the host interface.
  Assumes an external bus decoder presents status register accesses
  that stay stable across a rising edge of the link clock, and that
  command queue, response queue and command engine report their events
  as single pulses on clk.
*/
`timescale 1ns/100ps

module smsh_status #(
  parameter int IDLE_READY_CYCLES  = smsh_pkg::IDLE_READY_CYC,
  parameter int VALID_FLAG_CYCLES  = smsh_pkg::VALID_FLAG_CYC,
  parameter int COUNT_VALID_CYCLES = smsh_pkg::COUNT_VALID_CYC,
  parameter int SIZE_WIDTH         = 32
) (
  // Clock and reset.
  input  wire logic                             clk,
  input  wire logic                             rst,
  // Link clock pin.
  input  wire logic                             linkClk,
  // Status register access, taken at a link clock rising edge.
  input  wire logic                             stsWrite,
  input  wire logic [7:0]                       stsWrData,
  input  wire logic                             stsRead,
  output logic [smsh_pkg::STS_WIDTH-1:0]        stsRdData,
  output logic                                  stsRdWait,
  // Command queue side.
  input  wire logic                             cmdByteIn,
  input  wire logic                             cmdSizeValid,
  input  wire logic [SIZE_WIDTH-1:0]            cmdSize,
  input  wire logic                             cmdQueueEmpty,
  input  wire logic [15:0]                      cmdQueueSpace,
  output logic                                  cmdAccept,
  // Response queue side.
  input  wire logic                             rspByteOut,
  input  wire logic                             rspLastOut,
  input  wire logic                             rspQueueEmpty,
  input  wire logic [15:0]                      rspQueueCount,
  output logic                                  rspRewind,
  // Command engine and queue control.
  input  wire logic                             execDone,
  output logic                                  execStart,
  output logic                                  abortReq,
  output logic                                  queueClear,
  output smsh_pkg::smsh_state_t                 stateOut
);

  import smsh_pkg::*;

  // Parameter values the logic cannot serve stop elaboration.
  if (IDLE_READY_CYCLES < 1 || VALID_FLAG_CYCLES <= SETTLE_CYC ||
      COUNT_VALID_CYCLES < 1 || SIZE_WIDTH < 1 ||
      SIZE_WIDTH > 32) begin : gBadParams
    $error("smsh_status: unsupported parameter value");
  end

  typedef struct packed {
    smsh_state_t            state;
    logic [31:0]            timer;
    logic [3:0]             settle;
    logic                   valid;
    logic                   avail;
    logic                   wanted;
    logic [SIZE_WIDTH-1:0]  received;
    logic [15:0]            allow;
    logic [STS_WIDTH-1:0]   rdData;
    logic                   execStart;
    logic                   abortReq;
    logic                   queueClear;
    logic                   rspRewind;
  } smsh_regs_t;

  smsh_regs_t r_reg;
  smsh_regs_t r_next;

  logic linkLevel;
  logic linkRise;

  smsh_edge_sync linkSync (
    .clk   (clk),
    .rst   (rst),
    .pinIn (linkClk),
    .level (linkLevel),
    .rise  (linkRise)
  );

  logic       wrTaken;
  logic       wrReady;
  logic       wrGo;
  logic       wrRetry;
  logic       rdTaken;
  logic [SIZE_WIDTH-1:0] receivedInc;

  // Strobes are taken on a sampled rising edge of the link clock.
  assign wrTaken = stsWrite && linkRise && $onehot(stsWrData);
  assign wrReady = wrTaken && stsWrData[READY_BIT];
  assign wrGo    = wrTaken && stsWrData[GO_BIT];
  assign wrRetry = wrTaken && stsWrData[RETRY_BIT];
  assign rdTaken = stsRead && linkRise;
  assign receivedInc = r_reg.received + {{(SIZE_WIDTH-1){1'b0}}, 1'b1};

  always_comb begin
    r_next            = r_reg;
    r_next.execStart  = 1'b0;
    r_next.abortReq   = 1'b0;
    r_next.queueClear = 1'b0;
    r_next.rspRewind  = 1'b0;
    if (r_reg.timer != 32'h00000000) begin
      r_next.timer = r_reg.timer - 32'h00000001;
    end

    unique case (r_reg.state)
      ST_IDLE: begin
        if (wrReady) begin
          r_next.state      = ST_PREPARE;
          r_next.queueClear = 1'b1;
          r_next.timer      = 32'(IDLE_READY_CYCLES - 1);
        end
      end
      ST_PREPARE: begin
        if (cmdQueueEmpty && rspQueueEmpty) begin
          r_next.state    = ST_READY;
          r_next.wanted   = 1'b1;
          r_next.received = '0;
        end else if (r_reg.timer == 32'h00000000) begin
          r_next.state = ST_IDLE;
        end
      end
      ST_READY: begin
        if (cmdByteIn) begin
          r_next.state    = ST_RECEPTION;
          r_next.received = receivedInc;
        end
      end
      ST_RECEPTION: begin
        if (wrReady) begin
          r_next.state      = ST_IDLE;
          r_next.abortReq   = 1'b1;
          r_next.queueClear = 1'b1;
          r_next.wanted     = 1'b0;
        end else if (wrGo) begin
          r_next.state     = ST_EXECUTION;
          r_next.execStart = 1'b1;
          r_next.wanted    = 1'b0;
        end else if (cmdByteIn) begin
          r_next.received = receivedInc;
        end
      end
      ST_EXECUTION: begin
        if (wrReady) begin
          r_next.state      = ST_IDLE;
          r_next.abortReq   = 1'b1;
          r_next.queueClear = 1'b1;
        end else if (execDone) begin
          r_next.state = ST_COMPLETION;
          r_next.avail = 1'b1;
        end
      end
      ST_COMPLETION: begin
        if (wrReady) begin
          r_next.state      = ST_PREPARE;
          r_next.queueClear = 1'b1;
          r_next.avail      = 1'b0;
          r_next.timer      = 32'(IDLE_READY_CYCLES - 1);
        end else if (wrRetry) begin
          r_next.rspRewind = 1'b1;
          r_next.avail     = 1'b1;
        end else if (rspLastOut) begin
          r_next.avail = 1'b0;
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase

    // The wanted flag follows the byte count against the size field.
    if (r_reg.state == ST_RECEPTION && !wrReady && !wrGo) begin
      r_next.wanted = !(cmdSizeValid && r_next.received >= cmdSize);
    end

    // A data cycle invalidates the flags until they have settled.
    if (cmdByteIn || rspByteOut || wrTaken) begin
      r_next.valid  = 1'b0;
      r_next.settle = 4'(SETTLE_CYC);
    end else if (r_reg.settle != 4'h0) begin
      r_next.settle = r_reg.settle - 4'h1;
    end else begin
      r_next.valid = 1'b1;
    end

    // The allowance is refreshed only while the flags are settled.
    if (r_reg.valid) begin
      r_next.allow = r_reg.avail ? rspQueueCount :
                     (cmdAccept ? cmdQueueSpace : 16'h0000);
    end

    // Read data is captured once the status is known to be correct.
    if (rdTaken && r_reg.valid) begin
      r_next.rdData = '0;
      r_next.rdData[ALLOW_MSB:ALLOW_LSB] = r_reg.allow;
      r_next.rdData[VALID_BIT]  = r_reg.valid;
      r_next.rdData[READY_BIT]  = (r_reg.state == ST_READY);
      r_next.rdData[AVAIL_BIT]  = r_reg.avail;
      r_next.rdData[EXPECT_BIT] = r_reg.wanted;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg          <= '0;
      r_reg.state    <= ST_IDLE;
      r_reg.rdData   <= STS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // Host reads are held off while the flags may still be changing.
  assign stsRdWait  = stsRead && !r_reg.valid;
  assign stsRdData  = r_reg.rdData;
  // Data is dropped outside Ready and Reception, and in Reception once no more bytes are wanted.
  assign cmdAccept  = (r_reg.state == ST_READY) ||
                      (r_reg.state == ST_RECEPTION && r_reg.wanted);
  assign rspRewind  = r_reg.rspRewind;
  assign execStart  = r_reg.execStart;
  assign abortReq   = r_reg.abortReq;
  assign queueClear = r_reg.queueClear;
  assign stateOut   = r_reg.state;

endmodule // smsh_status

// >>> verilog/smsh_pkg.sv
/*
  Constants for the status register and command handshake block.
  Assumes a 20 MHz device clock and a sampled link clock.
*/
package smsh_pkg;

  localparam int CLK_PERIOD_NS = 50;

  // Status register field positions.
  localparam int RETRY_BIT  = 1;
  localparam int EXPECT_BIT = 3;
  localparam int AVAIL_BIT  = 4;
  localparam int GO_BIT     = 5;
  localparam int READY_BIT  = 6;
  localparam int VALID_BIT  = 7;
  localparam int ALLOW_LSB  = 8;
  localparam int ALLOW_MSB  = 23;
  localparam int STS_WIDTH  = 24;

  // Longest allowed times, in nanoseconds.
  localparam int IDLE_READY_NS  = 2000000;
  localparam int VALID_FLAG_NS  = 750000;
  localparam int COUNT_VALID_NS = 750000;

  // Longest times round down to whole cycles.
  localparam int IDLE_READY_CYC  = IDLE_READY_NS / CLK_PERIOD_NS;
  localparam int VALID_FLAG_CYC  = VALID_FLAG_NS / CLK_PERIOD_NS;
  localparam int COUNT_VALID_CYC = COUNT_VALID_NS / CLK_PERIOD_NS;

  // Cycles the flags take to settle after a data cycle.
  localparam int SETTLE_CYC = 4;

  localparam logic [STS_WIDTH-1:0] STS_RESET = 24'h000000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREPARE,
    ST_READY,
    ST_RECEPTION,
    ST_EXECUTION,
    ST_COMPLETION
  } smsh_state_t;

endpackage

// >>> verilog/smsh_edge_sync.sv
/*
  Three-stage synchroniser with edge detection for one pin.
  Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/100ps
module smsh_edge_sync (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Pin and results.
  input  wire logic pinIn,
  output logic      level,
  output logic      rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
    logic rise;
  } smsh_sync_t;

  smsh_sync_t r_reg;
  smsh_sync_t r_next;

  // A change counts once the second and third stages agree.
  always_comb begin
    r_next      = r_reg;
    r_next.s1   = pinIn;
    r_next.s2   = r_reg.s1;
    r_next.s3   = r_reg.s2;
    r_next.rise = 1'b0;
    if (r_reg.s2 == r_reg.s3 && r_reg.s3 != r_reg.stable) begin
      r_next.stable = r_reg.s3;
      r_next.rise   = r_reg.s3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level = r_reg.stable;
  assign rise  = r_reg.rise;

endmodule // smsh_edge_sync

// >>> tb/smsh_status_properties.sv
/*
  Checker for the status handshake block.
  Assumes it is bound into smsh_status.
*/
`timescale 1ns/100ps
module smsh_status_checker #(
  parameter int VALID_FLAG_CYCLES = 10
) (
  // Clock and reset.
  input logic                  clk,
  input logic                  rst,
  // Watched ports.
  input logic                  stsRdWait,
  input logic [23:0]           stsRdData,
  input logic                  cmdQueueEmpty,
  input logic                  rspQueueEmpty,
  input logic                  execDone,
  input logic                  execStart,
  input logic                  abortReq,
  input logic                  queueClear,
  input smsh_pkg::smsh_state_t stateOut
);
  import smsh_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ready_entry;
    $changed(stateOut) && stateOut == ST_READY
      |-> $past(cmdQueueEmpty && rspQueueEmpty);
  endproperty
  a_ready_entry: assert property (p_ready_entry)
    else $error("Ready entered with a queue busy.");
  property p_go;
    $rose(stateOut == ST_EXECUTION)
      |-> $past(stateOut) == ST_RECEPTION ##[0:1] execStart;
  endproperty
  a_go: assert property (p_go)
    else $error("Execution not started from reception.");
  property p_done;
    stateOut == ST_EXECUTION && execDone |=> stateOut == ST_COMPLETION;
  endproperty
  a_done: assert property (p_done)
    else $error("Completion not entered.");
  property p_abort;
    abortReq |-> queueClear && stateOut == ST_IDLE
      && $past(stateOut) inside {ST_RECEPTION, ST_EXECUTION};
  endproperty
  a_abort: assert property (p_abort)
    else $error("Abort out of place.");
  property p_wait;
    stsRdWait |-> ##[1:VALID_FLAG_CYCLES] !stsRdWait;
  endproperty
  a_wait: assert property (p_wait)
    else $error("Status read held too long.");
  property p_wo_zero;
    !stsRdData[5] && stsRdData[2:0] == 3'h0;
  endproperty
  a_wo_zero: assert property (p_wo_zero)
    else $error("Trigger bit reads one.");
  property p_capture;
    $changed(stsRdData) && stsRdData != 24'h0 |-> stsRdData[7];
  endproperty
  a_capture: assert property (p_capture)
    else $error("Status captured while not valid.");
  property p_ready_flags;
    stsRdData[6] |-> stsRdData[3] && !stsRdData[4];
  endproperty
  a_ready_flags: assert property (p_ready_flags)
    else $error("Ready read with wrong flags.");
endmodule // smsh_status_checker

bind smsh_status smsh_status_checker #(
  .VALID_FLAG_CYCLES(VALID_FLAG_CYCLES)
) props (
  .clk(clk), .rst(rst), .stsRdWait(stsRdWait), .stsRdData(stsRdData),
  .cmdQueueEmpty(cmdQueueEmpty), .rspQueueEmpty(rspQueueEmpty),
  .execDone(execDone), .execStart(execStart), .abortReq(abortReq),
  .queueClear(queueClear), .stateOut(stateOut)
);

// >>> tb/smsh_host_model.sv
/*
  Host model pacing status accesses on a 400 ns link clock.
  Assumes clk is the 50 ns device clock.
*/
`timescale 1ns/100ps
module smsh_host_model (
  // Clock.
  input wire logic        clk,
  // Status access pins.
  output logic            linkClk = 1'h0,
  output logic            stsWrite = 1'h0,
  output logic [7:0]      stsWrData = 8'hA5,
  output logic            stsRead = 1'h0,
  input wire logic        stsRdWait,
  input wire logic [23:0] stsRdData
);
  // Link clock runs only during an access, one 400 ns period per write or per read attempt.
  // The wait flag is sampled between the sampled rise and the taking edge.
  task automatic pace(output bit free);
    linkClk = 1'h1;
    repeat (4) @(negedge clk);
    free = (stsRdWait === 1'h0);
    linkClk = 1'h0;
    repeat (4) @(negedge clk);
  endtask
  // The request stands until the link clock has fallen and settled.
  task automatic wr(input logic [7:0] d);
    bit ignored;
    @(negedge clk);
    stsWrite = 1'h1;
    stsWrData = d;
    repeat (3) @(negedge clk);
    pace(ignored);
    stsWrite = 1'h0;
    stsWrData = ~d;
  endtask
  task automatic rd(output logic [23:0] d, output bit ok);
    ok = 1'h0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge clk);
      stsRead = 1'h1;
      repeat (3) @(negedge clk);
      pace(ok);
    end
    d = stsRdData;
    stsRead = 1'h0;
  endtask
endmodule // smsh_host_model

// >>> tb/tb_top.sv
/*
  Self-checking bench for the status handshake block.
  Assumes the host model paces every status access.
*/
`timescale 1ns/100ps
module tb_top;
  import smsh_pkg::*;
  localparam int IRC = 20;
  localparam int EV_BYTE = 0, EV_DONE = 1, EV_OUT = 2, EV_LAST = 3;
  logic        clk = 1'h0, rst = 1'h1;
  logic        linkClk, stsWrite, stsRead, stsRdWait, cmdAccept;
  logic        rspRewind, execStart, abortReq, queueClear;
  logic [7:0]  stsWrData;
  logic [23:0] stsRdData, lastRd;
  logic        cmdByteIn = 1'h0, cmdSizeValid = 1'h0, execDone = 1'h0;
  logic        cmdQueueEmpty = 1'h1, rspQueueEmpty = 1'h1;
  logic        rspByteOut = 1'h0, rspLastOut = 1'h0;
  logic [31:0] cmdSize = 32'h0;
  logic [15:0] cmdQueueSpace = 16'h10, rspQueueCount = 16'h0;
  smsh_state_t stateOut;
  int          errCount = 0, nTests = 0, nRewind = 0;

  always #25 clk = ~clk;

  // Rewind pulses are counted where they stand settled.
  always @(negedge clk) begin
    if (rspRewind === 1'h1) begin
      nRewind++;
    end
  end

  smsh_status #(.IDLE_READY_CYCLES(IRC), .VALID_FLAG_CYCLES(10),
    .COUNT_VALID_CYCLES(10)) dut (
    .clk(clk), .rst(rst), .linkClk(linkClk), .stsWrite(stsWrite),
    .stsWrData(stsWrData), .stsRead(stsRead), .stsRdData(stsRdData),
    .stsRdWait(stsRdWait), .cmdByteIn(cmdByteIn),
    .cmdSizeValid(cmdSizeValid), .cmdSize(cmdSize),
    .cmdQueueEmpty(cmdQueueEmpty), .cmdQueueSpace(cmdQueueSpace),
    .cmdAccept(cmdAccept), .rspByteOut(rspByteOut),
    .rspLastOut(rspLastOut), .rspQueueEmpty(rspQueueEmpty),
    .rspQueueCount(rspQueueCount), .rspRewind(rspRewind),
    .execDone(execDone), .execStart(execStart), .abortReq(abortReq),
    .queueClear(queueClear), .stateOut(stateOut));
  smsh_host_model host (.clk(clk), .linkClk(linkClk),
    .stsWrite(stsWrite), .stsWrData(stsWrData), .stsRead(stsRead),
    .stsRdWait(stsRdWait), .stsRdData(stsRdData));

  task automatic reportAndStop();
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdChk(input string nm, input logic [7:0] exp);
    bit ok;
    host.rd(lastRd, ok);
    if (!ok) begin
      errCount++;
      reportAndStop();
    end
    chk(nm, {16'h0, lastRd[7:0]}, {16'h0, exp});
  endtask
  task automatic waitSt(input smsh_state_t s, input int n);
    for (int i = 0; i < n && stateOut !== s; i++) @(negedge clk);
    chk("state", 24'(stateOut), 24'(s));
    if (stateOut !== s) reportAndStop();
  endtask
  task automatic pls(input int w);
    @(negedge clk);
    cmdByteIn  = (w == EV_BYTE);
    execDone   = (w == EV_DONE);
    rspByteOut = (w == EV_OUT);
    rspLastOut = (w == EV_LAST);
    @(negedge clk);
    cmdByteIn  = 1'h0;
    execDone   = 1'h0;
    rspByteOut = 1'h0;
    rspLastOut = 1'h0;
  endtask

  task automatic tIdle();
    logic [7:0] bad [5] = '{8'h00, 8'h60, 8'h48, 8'h20, 8'h02};
    waitSt(ST_IDLE, 1);
    rdChk("initial", 8'h80);
    foreach (bad[i]) begin
      host.wr(bad[i]);
      waitSt(ST_IDLE, 2);
    end
  endtask
  task automatic tReady();
    host.wr(8'h40);
    waitSt(ST_READY, IRC);
    rdChk("ready", 8'hC8);
    chk("allowance", {8'h0, lastRd[23:8]}, 24'h10);
    chk("accept", {23'h0, cmdAccept}, 24'h1);
    host.wr(8'h40);
    waitSt(ST_READY, 2);
  endtask
  task automatic tCommand();
    cmdSizeValid = 1'h1;
    cmdSize = 32'h2;
    cmdQueueEmpty = 1'h0;
    pls(EV_BYTE);
    waitSt(ST_RECEPTION, 2);
    rdChk("first", 8'h88);
    pls(EV_BYTE);
    rdChk("full", 8'h80);
    chk("acceptFull", {23'h0, cmdAccept}, 24'h0);
    host.wr(8'h20);
    waitSt(ST_EXECUTION, 2);
  endtask
  task automatic tResponse();
    rspQueueEmpty = 1'h0;
    rspQueueCount = 16'h3;
    pls(EV_DONE);
    waitSt(ST_COMPLETION, 2);
    rdChk("pending", 8'h90);
    chk("count", {8'h0, lastRd[23:8]}, 24'h3);
    pls(EV_OUT);
    pls(EV_LAST);
    rdChk("drained", 8'h80);
    pls(EV_OUT);
    rdChk("empty", 8'h80);
    host.wr(8'h02);
    chk("rewind", 24'(nRewind), 24'h1);
    rdChk("resend", 8'h90);
    host.wr(8'h40);
    waitSt(ST_PREPARE, 2);
    rspQueueEmpty = 1'h1;
    cmdQueueEmpty = 1'h1;
    cmdQueueSpace = 16'h20;
    waitSt(ST_READY, IRC);
    rdChk("next", 8'hC8);
    chk("space", {8'h0, lastRd[23:8]}, 24'h20);
  endtask
  task automatic tAbort();
    pls(EV_BYTE);
    waitSt(ST_RECEPTION, 2);
    host.wr(8'h40);
    waitSt(ST_IDLE, 2);
    cmdQueueEmpty = 1'h0;
    host.wr(8'h40);
    waitSt(ST_PREPARE, 2);
    waitSt(ST_IDLE, IRC + 2);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'h0;
    tIdle();
    tReady();
    tCommand();
    tResponse();
    tAbort();
    reportAndStop();
  end
endmodule // tb_top
